// ---- design/pcerr_error_regs.sv ----
/*
  Error reporting register bank: uncorrectable mask and severity registers,
  correctable status register, and the upstream message choice.
  Assumes configuration accesses and error detectors run on ref_clk.
//
// How it works
// - mask bits 18 to 12 writable, one masks
// - mask bit 13 hides flow credit errors
// - mask bit 5 hides surprise down
// - mask bit 4 hides link protocol errors
// - reserved mask and severity bits read zero
// - bit 0 reads a fixed constant
// - severity one means fatal, zero nonfatal
// - severity bits 20:12, 5, 4 choose message
// - severity reset value 00032030 hex
// - status bits cleared only by writing one
// - retransmit timer expiry sets bit 12
// - retransmit count rollover sets bit 8
// - symbol error in link packet sets 7
// - symbol error in transaction packet sets 6
// - any symbol error sets bit 0
// - advisory nonfatal flag at bit 13
// - reserved status bits read zero
// - status register resets to zero
// - masked errors log nothing, send nothing
// - mask bits 20 and 19 writable
*/
`timescale 1ns/1ns
module pcerr_error_regs
  import pcerr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire pcerr_pkg::pcerr_addr_t cfg_addr,
  input wire logic [3:0] cfg_byte_en,
  input wire pcerr_pkg::pcerr_word_t cfg_wr_data,
  output pcerr_pkg::pcerr_word_t cfg_rd_data,
  output logic cfg_done,
  input wire pcerr_pkg::pcerr_word_t unc_event,
  input wire logic symbol_error,
  input wire logic rx_in_link_packet,
  input wire logic rx_in_transaction_packet,
  input wire logic retransmit_timeout,
  input wire logic retransmit_rollover,
  input wire logic unacked_pending,
  input wire logic advisory_nonfatal_event,
  output logic err_fatal_send,
  output logic err_nonfatal_send,
  output pcerr_pkg::pcerr_word_t unc_logged,
  output pcerr_pkg::pcerr_word_t unc_detected,
  output pcerr_pkg::pcerr_word_t cor_status
);
  import pcerr_pkg::*;

  // ==========================================================================
  // Declarations
  pcerr_word_t unc_mask;
  pcerr_word_t unc_sev;
  pcerr_word_t byte_mask;
  pcerr_word_t write_mask;
  pcerr_word_t next_unc_mask;
  pcerr_word_t next_unc_sev;
  pcerr_word_t next_rd_data;
  pcerr_word_t cor_set;
  pcerr_word_t cor_clear;
  pcerr_word_t reported;
  pcerr_word_t hide_vec;
  pcerr_word_t fatal_vec;
  logic hit_mask;
  logic hit_sev;
  logic hit_cor;
  logic pick_fatal;
  logic pick_nonfatal;
  logic unsupported_request_hide;
  logic end_to_end_crc_hide;
  logic malformed_packet_hide;
  logic receive_credit_overrun_hide;
  logic unexpected_completion_hide;
  logic completer_abort_hide;
  logic completion_timeout_hide;
  logic flow_credit_error_hide;
  logic poisoned_packet_hide;
  logic surprise_down_hide;
  logic link_protocol_error_hide;
  logic unsupported_request_fatal;
  logic end_to_end_crc_fatal;
  logic malformed_packet_fatal;
  logic receive_credit_overrun_fatal;
  logic unexpected_completion_fatal;
  logic completer_abort_fatal;
  logic completion_timeout_fatal;
  logic flow_credit_error_fatal;
  logic poisoned_packet_fatal;
  logic surprise_down_fatal;
  logic link_protocol_error_fatal;
  logic advisory_nonfatal_flag;
  logic retransmit_timer_expired;
  logic corrupt_link_packet;
  logic corrupt_transaction_packet;

  pcerr_sticky_if cor_if ();

  // ==========================================================================
  // Address decode
  always_comb begin
    hit_mask = (cfg_addr == PCERR_UNC_MASK_OFS);
    hit_sev = (cfg_addr == PCERR_UNC_SEV_OFS);
    hit_cor = (cfg_addr == PCERR_COR_STAT_OFS);
  end

  // ==========================================================================
  // Byte lane expansion
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_lane
      assign byte_mask[lane*8 +: 8] = {8{cfg_byte_en[lane]}};
    end
  endgenerate

  always_comb begin
    write_mask = byte_mask & PCERR_UNC_WRITABLE;
    next_unc_mask = (unc_mask & ~write_mask) | (cfg_wr_data & write_mask);
    next_unc_sev = (unc_sev & ~write_mask) | (cfg_wr_data & write_mask);
  end

  // ==========================================================================
  // Uncorrectable mask register
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      unc_mask <= PCERR_UNC_MASK_RESET;
    end else if (cfg_wr && hit_mask) begin
      unc_mask <= next_unc_mask;
    end
  end

  // ==========================================================================
  // Uncorrectable severity register
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      unc_sev <= PCERR_UNC_SEV_RESET;
    end else if (cfg_wr && hit_sev) begin
      unc_sev <= next_unc_sev;
    end
  end

  // ==========================================================================
  // Named fields
  always_comb begin
    unsupported_request_hide = unc_mask[PCERR_UNC_UNSUP_REQ_BIT];
    end_to_end_crc_hide = unc_mask[PCERR_UNC_E2E_CRC_BIT];
    malformed_packet_hide = unc_mask[PCERR_UNC_MALFORMED_BIT];
    receive_credit_overrun_hide = unc_mask[PCERR_UNC_CREDIT_OVR_BIT];
    unexpected_completion_hide = unc_mask[PCERR_UNC_UNEXP_CPL_BIT];
    completer_abort_hide = unc_mask[PCERR_UNC_CPL_ABORT_BIT];
    completion_timeout_hide = unc_mask[PCERR_UNC_CPL_TIMEOUT_BIT];
    flow_credit_error_hide = unc_mask[PCERR_UNC_FLOW_CREDIT_BIT];
    poisoned_packet_hide = unc_mask[PCERR_UNC_POISONED_BIT];
    surprise_down_hide = unc_mask[PCERR_UNC_SURPRISE_DOWN_BIT];
    link_protocol_error_hide = unc_mask[PCERR_UNC_LINK_PROTO_BIT];
    unsupported_request_fatal = unc_sev[PCERR_UNC_UNSUP_REQ_BIT];
    end_to_end_crc_fatal = unc_sev[PCERR_UNC_E2E_CRC_BIT];
    malformed_packet_fatal = unc_sev[PCERR_UNC_MALFORMED_BIT];
    receive_credit_overrun_fatal = unc_sev[PCERR_UNC_CREDIT_OVR_BIT];
    unexpected_completion_fatal = unc_sev[PCERR_UNC_UNEXP_CPL_BIT];
    completer_abort_fatal = unc_sev[PCERR_UNC_CPL_ABORT_BIT];
    completion_timeout_fatal = unc_sev[PCERR_UNC_CPL_TIMEOUT_BIT];
    flow_credit_error_fatal = unc_sev[PCERR_UNC_FLOW_CREDIT_BIT];
    poisoned_packet_fatal = unc_sev[PCERR_UNC_POISONED_BIT];
    surprise_down_fatal = unc_sev[PCERR_UNC_SURPRISE_DOWN_BIT];
    link_protocol_error_fatal = unc_sev[PCERR_UNC_LINK_PROTO_BIT];
  end

  // ==========================================================================
  // Field vectors for the message choice
  always_comb begin
    hide_vec = '0;
    hide_vec[PCERR_UNC_UNSUP_REQ_BIT] = unsupported_request_hide;
    hide_vec[PCERR_UNC_E2E_CRC_BIT] = end_to_end_crc_hide;
    hide_vec[PCERR_UNC_MALFORMED_BIT] = malformed_packet_hide;
    hide_vec[PCERR_UNC_CREDIT_OVR_BIT] = receive_credit_overrun_hide;
    hide_vec[PCERR_UNC_UNEXP_CPL_BIT] = unexpected_completion_hide;
    hide_vec[PCERR_UNC_CPL_ABORT_BIT] = completer_abort_hide;
    hide_vec[PCERR_UNC_CPL_TIMEOUT_BIT] = completion_timeout_hide;
    hide_vec[PCERR_UNC_FLOW_CREDIT_BIT] = flow_credit_error_hide;
    hide_vec[PCERR_UNC_POISONED_BIT] = poisoned_packet_hide;
    hide_vec[PCERR_UNC_SURPRISE_DOWN_BIT] = surprise_down_hide;
    hide_vec[PCERR_UNC_LINK_PROTO_BIT] = link_protocol_error_hide;
    fatal_vec = '0;
    fatal_vec[PCERR_UNC_UNSUP_REQ_BIT] = unsupported_request_fatal;
    fatal_vec[PCERR_UNC_E2E_CRC_BIT] = end_to_end_crc_fatal;
    fatal_vec[PCERR_UNC_MALFORMED_BIT] = malformed_packet_fatal;
    fatal_vec[PCERR_UNC_CREDIT_OVR_BIT] = receive_credit_overrun_fatal;
    fatal_vec[PCERR_UNC_UNEXP_CPL_BIT] = unexpected_completion_fatal;
    fatal_vec[PCERR_UNC_CPL_ABORT_BIT] = completer_abort_fatal;
    fatal_vec[PCERR_UNC_CPL_TIMEOUT_BIT] = completion_timeout_fatal;
    fatal_vec[PCERR_UNC_FLOW_CREDIT_BIT] = flow_credit_error_fatal;
    fatal_vec[PCERR_UNC_POISONED_BIT] = poisoned_packet_fatal;
    fatal_vec[PCERR_UNC_SURPRISE_DOWN_BIT] = surprise_down_fatal;
    fatal_vec[PCERR_UNC_LINK_PROTO_BIT] = link_protocol_error_fatal;
  end

  // ==========================================================================
  // Correctable event sources
  always_comb begin
    retransmit_timer_expired = retransmit_timeout & unacked_pending;
    corrupt_link_packet = symbol_error & rx_in_link_packet;
    corrupt_transaction_packet = symbol_error & rx_in_transaction_packet;
    advisory_nonfatal_flag = cor_if.status[PCERR_COR_ADVISORY_BIT];
    cor_set = PCERR_COR_STAT_RESET;
    cor_set[PCERR_COR_RETX_TIMER_BIT] = retransmit_timer_expired;
    cor_set[PCERR_COR_RETX_ROLL_BIT] = retransmit_rollover & unacked_pending;
    cor_set[PCERR_COR_LINK_PKT_BIT] = corrupt_link_packet;
    cor_set[PCERR_COR_TRANS_PKT_BIT] = corrupt_transaction_packet;
    cor_set[PCERR_COR_SYMBOL_BIT] = symbol_error;
    cor_set[PCERR_COR_ADVISORY_BIT] = advisory_nonfatal_event;
    cor_clear = (cfg_wr && hit_cor) ? (cfg_wr_data & byte_mask) : PCERR_COR_STAT_RESET;
  end

  assign cor_if.set_bits = cor_set;
  assign cor_if.clear_bits = cor_clear;

  pcerr_sticky_bank #(
    .IMPLEMENTED(PCERR_COR_IMPLEMENTED),
    .RESET_VALUE(PCERR_COR_STAT_RESET)
  ) u_cor_bank (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .sb(cor_if.bank)
  );

  // ==========================================================================
  // Uncorrectable message choice
  pcerr_msg_select u_msg (
    .events(unc_event),
    .hide(hide_vec),
    .fatal(fatal_vec),
    .reported(reported),
    .send_fatal(pick_fatal),
    .send_nonfatal(pick_nonfatal)
  );

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      err_fatal_send <= 1'b0;
      err_nonfatal_send <= 1'b0;
    end else begin
      err_fatal_send <= pick_fatal;
      err_nonfatal_send <= pick_nonfatal;
    end
  end

  // ==========================================================================
  // Detection and logging strobes
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      unc_detected <= PCERR_UNC_MASK_RESET;
      unc_logged <= PCERR_UNC_MASK_RESET;
    end else begin
      unc_detected <= unc_event & PCERR_UNC_WRITABLE;
      unc_logged <= reported;
    end
  end

  // ==========================================================================
  // Read data
  always_comb begin
    next_rd_data = PCERR_UNMAPPED_READ;
    if (hit_mask) begin
      next_rd_data = unc_mask & PCERR_UNC_WRITABLE;
      next_rd_data[PCERR_UNC_UNDEF_BIT] = PCERR_UNC_UNDEF_VALUE;
    end else if (hit_sev) begin
      next_rd_data = unc_sev & PCERR_UNC_WRITABLE;
      next_rd_data[PCERR_UNC_UNDEF_BIT] = PCERR_UNC_UNDEF_VALUE;
    end else if (hit_cor) begin
      next_rd_data = cor_if.status & PCERR_COR_IMPLEMENTED;
      next_rd_data[PCERR_COR_ADVISORY_BIT] = advisory_nonfatal_flag;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cfg_rd_data <= PCERR_UNMAPPED_READ;
    end else if (cfg_rd) begin
      cfg_rd_data <= next_rd_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cfg_done <= 1'b0;
    end else begin
      cfg_done <= cfg_rd | cfg_wr;
    end
  end

  // ==========================================================================
  // Status copy for the outside
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cor_status <= PCERR_COR_STAT_RESET;
    end else begin
      cor_status <= cor_if.status;
    end
  end

endmodule

// ---- design/pcerr_msg_select.sv ----
/*
  Chooses the upstream message for uncorrectable error events.
  Assumes event, mask and severity vectors share the same bit layout.
*/
`timescale 1ns/1ns
module pcerr_msg_select
  import pcerr_pkg::*;
(
  input wire pcerr_pkg::pcerr_word_t events,
  input wire pcerr_pkg::pcerr_word_t hide,
  input wire pcerr_pkg::pcerr_word_t fatal,
  output pcerr_pkg::pcerr_word_t reported,
  output logic send_fatal,
  output logic send_nonfatal
);
  import pcerr_pkg::*;

  // ==========================================================================
  // Masked classes are not reported
  always_comb begin
    reported = events & ~hide & PCERR_UNC_WRITABLE;
    send_fatal = |(reported & fatal);
    send_nonfatal = |(reported & ~fatal);
  end
endmodule

// ---- design/pcerr_pkg.sv ----
/*
  Constants for the error reporting register bank: offsets, field positions,
  writable and implemented bit sets and reset values.
  Assumes configuration accesses carry a 12-bit byte address of an aligned word.
*/
package pcerr_pkg;

  // ==========================================================================
  // Types
  typedef logic [31:0] pcerr_word_t;
  typedef logic [11:0] pcerr_addr_t;

  // ==========================================================================
  // Register offsets
  localparam pcerr_addr_t PCERR_UNC_MASK_OFS = 12'h108;
  localparam pcerr_addr_t PCERR_UNC_SEV_OFS = 12'h10C;
  localparam pcerr_addr_t PCERR_COR_STAT_OFS = 12'h110;

  // ==========================================================================
  // Uncorrectable field positions
  localparam int unsigned PCERR_UNC_UNSUP_REQ_BIT = 20;
  localparam int unsigned PCERR_UNC_E2E_CRC_BIT = 19;
  localparam int unsigned PCERR_UNC_MALFORMED_BIT = 18;
  localparam int unsigned PCERR_UNC_CREDIT_OVR_BIT = 17;
  localparam int unsigned PCERR_UNC_UNEXP_CPL_BIT = 16;
  localparam int unsigned PCERR_UNC_CPL_ABORT_BIT = 15;
  localparam int unsigned PCERR_UNC_CPL_TIMEOUT_BIT = 14;
  localparam int unsigned PCERR_UNC_FLOW_CREDIT_BIT = 13;
  localparam int unsigned PCERR_UNC_POISONED_BIT = 12;
  localparam int unsigned PCERR_UNC_SURPRISE_DOWN_BIT = 5;
  localparam int unsigned PCERR_UNC_LINK_PROTO_BIT = 4;
  localparam int unsigned PCERR_UNC_UNDEF_BIT = 0;
  localparam logic PCERR_UNC_UNDEF_VALUE = 1'b0;

  // ==========================================================================
  // Correctable field positions
  localparam int unsigned PCERR_COR_ADVISORY_BIT = 13;
  localparam int unsigned PCERR_COR_RETX_TIMER_BIT = 12;
  localparam int unsigned PCERR_COR_RETX_ROLL_BIT = 8;
  localparam int unsigned PCERR_COR_LINK_PKT_BIT = 7;
  localparam int unsigned PCERR_COR_TRANS_PKT_BIT = 6;
  localparam int unsigned PCERR_COR_SYMBOL_BIT = 0;

  // ==========================================================================
  // Writable and implemented bits, reset values
  localparam pcerr_word_t PCERR_UNC_WRITABLE = 32'h001FF030;
  localparam pcerr_word_t PCERR_COR_IMPLEMENTED = 32'h000031C1;
  localparam pcerr_word_t PCERR_UNC_MASK_RESET = 32'h00000000;
  localparam pcerr_word_t PCERR_UNC_SEV_RESET = 32'h00032030;
  localparam pcerr_word_t PCERR_COR_STAT_RESET = 32'h00000000;
  localparam pcerr_word_t PCERR_UNMAPPED_READ = 32'h00000000;

endpackage

// ---- design/pcerr_sticky_bank.sv ----
/*
  Bank of sticky status bits cleared by writing one.
  Assumes set and clear masks are valid every cycle; unimplemented bits stay zero.
*/
`timescale 1ns/1ns
module pcerr_sticky_bank
  import pcerr_pkg::*;
#(
  parameter pcerr_word_t IMPLEMENTED = PCERR_COR_IMPLEMENTED,
  parameter pcerr_word_t RESET_VALUE = PCERR_COR_STAT_RESET
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  pcerr_sticky_if.bank sb
);
  import pcerr_pkg::*;

  wire pcerr_word_t next_status;
  pcerr_word_t status_bits;

  // ==========================================================================
  // Next value per bit
  genvar i;
  generate
    for (i = 0; i < 32; i++) begin : g_bit
      if (IMPLEMENTED[i]) begin : g_impl
        assign next_status[i] = sb.set_bits[i] | (status_bits[i] & ~sb.clear_bits[i]);
      end else begin : g_rsvd
        assign next_status[i] = 1'b0;
      end
    end
  endgenerate

  // ==========================================================================
  // Status register
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      status_bits <= RESET_VALUE & IMPLEMENTED;
    end else begin
      status_bits <= next_status;
    end
  end

  assign sb.status = status_bits;
endmodule

// ---- design/pcerr_sticky_if.sv ----
/*
  Carrier between the register front end and the sticky status bank.
  Assumes one clock domain; set and clear are one-cycle strobes.
*/
`timescale 1ns/1ns
interface pcerr_sticky_if;
  import pcerr_pkg::*;
  pcerr_word_t set_bits;
  pcerr_word_t clear_bits;
  pcerr_word_t status;

  // ==========================================================================
  // Views
  modport bank (input set_bits, input clear_bits, output status);
  modport ctrl (output set_bits, output clear_bits, input status);
endinterface

// ---- verif/pcerr_error_regs_asserts.sv ----
/*
  Concurrent checks for the error reporting register bank.
  Assumes it is bound to pcerr_error_regs and sees only its ports.
*/
`timescale 1ns/1ns
module pcerr_error_regs_asserts
  import pcerr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire pcerr_pkg::pcerr_addr_t cfg_addr,
  input wire pcerr_pkg::pcerr_word_t cfg_rd_data,
  input wire logic symbol_error,
  input wire logic rx_in_link_packet,
  input wire logic rx_in_transaction_packet,
  input wire logic retransmit_timeout,
  input wire logic retransmit_rollover,
  input wire logic unacked_pending,
  input wire logic advisory_nonfatal_event,
  input wire logic err_fatal_send,
  input wire logic err_nonfatal_send,
  input wire pcerr_pkg::pcerr_word_t unc_event,
  input wire pcerr_pkg::pcerr_word_t unc_logged,
  input wire pcerr_pkg::pcerr_word_t unc_detected,
  input wire pcerr_pkg::pcerr_word_t cor_status
);
  import pcerr_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // ==========================================================================
  // Sequences
  sequence unc_read_s;
    cfg_rd && (cfg_addr == PCERR_UNC_MASK_OFS || cfg_addr == PCERR_UNC_SEV_OFS);
  endsequence
  sequence status_clear_s;
    $past(cfg_wr, 2) && $past(cfg_addr, 2) == PCERR_COR_STAT_OFS;
  endsequence

  // ==========================================================================
  // Register reads
  rsvd_read_zero_a: assert property (unc_read_s |=> (cfg_rd_data & 32'hFFE00FCE) == 32'h00000000)
    else $error("reserved mask or severity bits read nonzero");
  undef_bit_const_a: assert property (unc_read_s |=> cfg_rd_data[0] == PCERR_UNC_UNDEF_VALUE)
    else $error("bit 0 of mask or severity not constant");

  // ==========================================================================
  // Correctable status
  rsvd_status_zero_a: assert property ((cor_status & ~PCERR_COR_IMPLEMENTED) == 32'h00000000)
    else $error("reserved status bits nonzero");
  any_symbol_sets_a: assert property (symbol_error |-> ##2 cor_status[0])
    else $error("symbol error did not set bit 0");
  link_symbol_sets_a: assert property (symbol_error && rx_in_link_packet |-> ##2 cor_status[7])
    else $error("link packet symbol error did not set bit 7");
  trans_symbol_sets_a: assert property (symbol_error && rx_in_transaction_packet |-> ##2 cor_status[6])
    else $error("transaction packet symbol error did not set bit 6");
  retx_timer_sets_a: assert property (retransmit_timeout && unacked_pending |-> ##2 cor_status[12])
    else $error("retransmit timer expiry did not set bit 12");
  retx_roll_sets_a: assert property (retransmit_rollover && unacked_pending |-> ##2 cor_status[8])
    else $error("retransmit rollover did not set bit 8");
  advisory_sets_a: assert property (advisory_nonfatal_event |-> ##2 cor_status[13])
    else $error("advisory event did not set bit 13");
  sticky_hold_a: assert property ((|($past(cor_status) & ~cor_status)) |-> status_clear_s)
    else $error("status bit cleared without a write");

  // ==========================================================================
  // Uncorrectable reporting
  logged_in_detected_a: assert property ((unc_logged & ~unc_detected) == 32'h00000000)
    else $error("logged class not detected");
  detect_all_a: assert property (1'b1 |=> unc_detected == ($past(unc_event) & PCERR_UNC_WRITABLE))
    else $error("detected classes do not follow events");
  send_iff_logged_a: assert property ((err_fatal_send || err_nonfatal_send) == (unc_logged != 32'h0))
    else $error("message send does not match logged classes");
endmodule

// ---- verif/pcerr_error_regs_test.sv ----
/*
  Self-checking bench for the error reporting register bank.
  Assumes the checker and the root model are compiled before it.
*/
`timescale 1ns/1ns
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; $display("BAD %s exp %h got %h", n, e, g); end end
module pcerr_error_regs_test;
  import pcerr_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic cfg_rd = 1'b0;
  logic cfg_wr = 1'b0;
  pcerr_addr_t cfg_addr = '0;
  logic [3:0] cfg_byte_en = '0;
  pcerr_word_t cfg_wr_data = '0;
  pcerr_word_t unc_event = '0;
  logic [6:0] cor_in = '0;
  pcerr_word_t cfg_rd_data;
  pcerr_word_t unc_logged;
  pcerr_word_t unc_detected;
  pcerr_word_t cor_status;
  logic cfg_done;
  logic err_fatal_send;
  logic err_nonfatal_send;
  int error_cnt = 0;
  int check_count = 0;

  always #50 ref_clk = ~ref_clk;

  pcerr_error_regs u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en), .cfg_wr_data(cfg_wr_data), .cfg_rd_data(cfg_rd_data),
    .cfg_done(cfg_done), .unc_event(unc_event), .symbol_error(cor_in[0]), .rx_in_link_packet(cor_in[1]),
    .rx_in_transaction_packet(cor_in[2]), .retransmit_timeout(cor_in[3]), .retransmit_rollover(cor_in[4]),
    .unacked_pending(cor_in[5]), .advisory_nonfatal_event(cor_in[6]), .err_fatal_send(err_fatal_send),
    .err_nonfatal_send(err_nonfatal_send), .unc_logged(unc_logged), .unc_detected(unc_detected),
    .cor_status(cor_status));
  pcerr_root_model u_root (.ref_clk(ref_clk), .reset_n(reset_n), .err_fatal_send(err_fatal_send),
    .err_nonfatal_send(err_nonfatal_send));

  // ==========================================================================
  // Bus and event tasks
  task automatic wr(input pcerr_addr_t a, input pcerr_word_t d, input logic [3:0] be);
    @(posedge ref_clk);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wr_data <= d;
    cfg_byte_en <= be;
    @(posedge ref_clk);
    cfg_wr <= 1'b0;
    #1;
    `CHK("write done", 1'b1, cfg_done)
  endtask
  task automatic rd(input pcerr_addr_t a, input pcerr_word_t e);
    @(posedge ref_clk);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge ref_clk);
    cfg_rd <= 1'b0;
    #1;
    `CHK("read done", 1'b1, cfg_done)
    `CHK("read data", e, cfg_rd_data)
  endtask
  task automatic ev(input pcerr_word_t u, input logic [6:0] c);
    @(posedge ref_clk);
    unc_event <= u;
    cor_in <= c;
    @(posedge ref_clk);
    unc_event <= '0;
    cor_in <= '0;
    #1;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    rd(PCERR_UNC_SEV_OFS, 32'h00032030);
    rd(PCERR_COR_STAT_OFS, 32'h00000000);
    rd(PCERR_UNC_MASK_OFS, 32'h00000000);
  endtask
  task automatic t_regs();
    wr(PCERR_UNC_MASK_OFS, 32'hFFFFFFFF, 4'hF);
    rd(PCERR_UNC_MASK_OFS, 32'h001FF030);
    wr(PCERR_UNC_SEV_OFS, 32'hFFFFFFFF, 4'hF);
    rd(PCERR_UNC_SEV_OFS, 32'h001FF030);
    wr(PCERR_UNC_SEV_OFS, 32'h00000000, 4'h2);
    rd(PCERR_UNC_SEV_OFS, 32'h001F0030);
    wr(12'h200, 32'hFFFFFFFF, 4'hF);
    rd(12'h200, 32'h00000000);
  endtask
  task automatic t_msg();
    wr(PCERR_UNC_MASK_OFS, 32'h00000000, 4'hF);
    wr(PCERR_UNC_SEV_OFS, 32'h00002000, 4'hF);
    ev(32'h00003000, 7'h00);
    `CHK("logged", 32'h00003000, unc_logged)
    `CHK("fatal send", 1'b1, err_fatal_send)
    `CHK("nonfatal send", 1'b1, err_nonfatal_send)
    wr(PCERR_UNC_SEV_OFS, 32'h00000000, 4'hF);
    wr(PCERR_UNC_MASK_OFS, 32'h00001000, 4'hF);
    ev(32'h00003001, 7'h00);
    `CHK("masked logged", 32'h00002000, unc_logged)
    `CHK("masked detected", 32'h00003000, unc_detected)
    `CHK("fatal after change", 1'b0, err_fatal_send)
    @(posedge ref_clk);
    #1;
    `CHK("root fatal", 1, u_root.fatal_cnt)
    `CHK("root nonfatal", 2, u_root.nonfatal_cnt)
    @(posedge ref_clk);
    cfg_wr <= 1'b1;
    cfg_addr <= PCERR_UNC_SEV_OFS;
    cfg_wr_data <= 32'h00002000;
    cfg_byte_en <= 4'hF;
    unc_event <= 32'h00002000;
    @(posedge ref_clk);
    cfg_wr <= 1'b0;
    unc_event <= '0;
    #1;
    `CHK("old severity used", 1'b1, err_nonfatal_send)
    ev(32'h00002000, 7'h00);
    `CHK("new severity used", 1'b1, err_fatal_send)
  endtask
  task automatic t_status();
    ev(32'h0, 7'h18);
    rd(PCERR_COR_STAT_OFS, 32'h00000000);
    ev(32'h0, 7'h03);
    rd(PCERR_COR_STAT_OFS, 32'h00000081);
    ev(32'h0, 7'h3C);
    rd(PCERR_COR_STAT_OFS, 32'h00001181);
    ev(32'h0, 7'h45);
    rd(PCERR_COR_STAT_OFS, 32'h000031C1);
    wr(PCERR_COR_STAT_OFS, 32'h00000000, 4'hF);
    rd(PCERR_COR_STAT_OFS, 32'h000031C1);
    @(posedge ref_clk);
    cfg_wr <= 1'b1;
    cfg_addr <= PCERR_COR_STAT_OFS;
    cfg_wr_data <= 32'h00000001;
    cfg_byte_en <= 4'hF;
    cor_in <= 7'h01;
    @(posedge ref_clk);
    cfg_wr <= 1'b0;
    cor_in <= '0;
    rd(PCERR_COR_STAT_OFS, 32'h000031C1);
    wr(PCERR_COR_STAT_OFS, 32'hFFFFFFFF, 4'h1);
    rd(PCERR_COR_STAT_OFS, 32'h00003100);
    wr(PCERR_COR_STAT_OFS, 32'hFFFFFFFF, 4'hF);
    rd(PCERR_COR_STAT_OFS, 32'h00000000);
  endtask

  // ==========================================================================
  // Run control
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_reset();
    t_regs();
    t_msg();
    t_status();
    end_of_test();
  end
  initial begin
    #100000;
    error_cnt++;
    end_of_test();
  end
endmodule

bind pcerr_error_regs pcerr_error_regs_asserts u_chk (.ref_clk(ref_clk), .reset_n(reset_n), .cfg_rd(cfg_rd),
  .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_rd_data(cfg_rd_data), .symbol_error(symbol_error),
  .rx_in_link_packet(rx_in_link_packet), .rx_in_transaction_packet(rx_in_transaction_packet),
  .retransmit_timeout(retransmit_timeout), .retransmit_rollover(retransmit_rollover),
  .unacked_pending(unacked_pending), .advisory_nonfatal_event(advisory_nonfatal_event),
  .err_fatal_send(err_fatal_send), .err_nonfatal_send(err_nonfatal_send), .unc_event(unc_event),
  .unc_logged(unc_logged), .unc_detected(unc_detected), .cor_status(cor_status));

// ---- verif/pcerr_root_model.sv ----
/*
  Upstream receiver model: counts fatal and nonfatal error messages.
  Assumes message strobes are one-cycle pulses on ref_clk.
*/
`timescale 1ns/1ns
module pcerr_root_model (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic err_fatal_send,
  input wire logic err_nonfatal_send
);
  int fatal_cnt;
  int nonfatal_cnt;

  // ==========================================================================
  // Message intake, one message per pulse cycle
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      fatal_cnt <= 0;
      nonfatal_cnt <= 0;
    end else begin
      fatal_cnt <= fatal_cnt + int'(err_fatal_send === 1'b1);
      nonfatal_cnt <= nonfatal_cnt + int'(err_nonfatal_send === 1'b1);
    end
  end
endmodule
